// *** hdl/rtc_alarm_core.v ***
// Real-time clock time, date and alarm registers behind AXI4-Lite.
// Assumes one clock; the half-second timebase is divided down from it.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_consts.vh"
module rtc_alarm_core #(
   parameter integer HALF_SEC_CYCLES = `HALF_SEC_MS * `CLK_KHZ
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] awaddr,
   input wire awvalid,
   output reg awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output reg wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   input wire [7:0] araddr,
   input wire arvalid,
   output reg arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   output reg alarm_pulse
);

   // ----------------------------------------------------------------
   // Timebase constants
   // ----------------------------------------------------------------
   localparam [31:0] HALF_LAST = HALF_SEC_CYCLES - 1;
   localparam [31:0] SYNC_HIGH = HALF_SEC_CYCLES - `SYNC_GUARD_CYCLES;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   reg module_on;
   reg value_write_enable;
   reg half_second_status;
   reg alarm_read_unsafe_flag;
   reg alarm_enable;
   reg repeat_wrap;
   reg [3:0] alarm_interval_select;
   reg [7:0] alarm_repeat_count;
   reg [31:0] time_value;
   reg [31:0] date_value;
   reg [31:0] alarm_time;
   reg [31:0] alarm_date;
   reg [25:0] pre_cnt;
   reg sec_new;

   reg aw_full;
   reg w_full;
   reg [7:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;

   wire [31:0] time_next;
   wire [31:0] date_next;

   // ----------------------------------------------------------------
   // Calendar
   // ----------------------------------------------------------------
   bcd_calendar calendar (
      .time_now(time_value),
      .date_now(date_value),
      .time_next(time_next),
      .date_next(date_next)
   );

   // ----------------------------------------------------------------
   // Register images and decode
   // ----------------------------------------------------------------
   function addr_ok;
      input [7:0] a;
      begin
         case ({a[7:2], 2'b00})
            `CTRL_OFFSET, `ALARM_CTRL_OFFSET, `TIME_OFFSET,
            `DATE_OFFSET, `ALARM_TIME_OFFSET, `ALARM_DATE_OFFSET:
               addr_ok = 1'b1;
            default: addr_ok = 1'b0;
         endcase
      end
   endfunction

   function [31:0] reg_image;
      input [7:0] a;
      reg [31:0] v;
      begin
         v = 32'h00000000;
         case ({a[7:2], 2'b00})
            `CTRL_OFFSET: begin
               v[`CTRL_ON_BIT] = module_on;
               v[`CTRL_WREN_BIT] = value_write_enable;
               v[`CTRL_SYNC_BIT] = alarm_read_unsafe_flag;
               v[`CTRL_HALF_BIT] = half_second_status;
            end
            `ALARM_CTRL_OFFSET: begin
               v[`ENABLE_BIT] = alarm_enable;
               v[`WRAP_BIT] = repeat_wrap;
               v[`PULSE_BIT] = alarm_pulse;
               v[`SYNC_BIT] = alarm_read_unsafe_flag;
               v[`MASK_POS +: 4] = alarm_interval_select;
               v[`REPEAT_POS +: 8] = alarm_repeat_count;
            end
            `TIME_OFFSET: v = time_value & `TIME_MASK;
            `DATE_OFFSET: v = date_value & `DATE_MASK;
            `ALARM_TIME_OFFSET: v = alarm_time & `TIME_MASK;
            `ALARM_DATE_OFFSET: v = alarm_date & `ALARM_DATE_MASK;
            default: v = 32'h00000000;
         endcase
         reg_image = v;
      end
   endfunction

   // Byte lanes not strobed keep the value the register already holds
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nv;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[8 * i +: 8] = nv[8 * i +: 8];
            end
         end
      end
   endfunction

   wire do_write = aw_full && w_full && !bvalid;
   wire [7:0] wr_base = {aw_addr_q[7:2], 2'b00};
   wire [31:0] wv = merge(reg_image(aw_addr_q), w_data_q, w_strb_q);

   // ----------------------------------------------------------------
   // Timebase
   // ----------------------------------------------------------------
   wire half_tick = module_on && (pre_cnt == HALF_LAST[25:0]);
   wire sec_tick = half_tick && half_second_status;
   wire near_rollover = module_on &&
      (({6'h00, pre_cnt} >= SYNC_HIGH) ||
       ({6'h00, pre_cnt} < `SYNC_GUARD_CYCLES));

   // ----------------------------------------------------------------
   // Alarm compare
   // ----------------------------------------------------------------
   wire m_sec_u = time_value[`SEC_POS +: 4] == alarm_time[`SEC_POS +: 4];
   wire m_sec = time_value[`SEC_POS +: 7] == alarm_time[`SEC_POS +: 7];
   wire m_min_u = time_value[`MIN_POS +: 4] == alarm_time[`MIN_POS +: 4];
   wire m_min = time_value[`MIN_POS +: 7] == alarm_time[`MIN_POS +: 7];
   wire m_hour = time_value[`HOUR_POS +: 6] == alarm_time[`HOUR_POS +: 6];
   wire m_wday = date_value[`WDAY_POS +: 3] == alarm_date[`WDAY_POS +: 3];
   wire m_day = date_value[`DAY_POS +: 6] == alarm_date[`DAY_POS +: 6];
   wire m_month = date_value[`MONTH_POS +: 5] ==
                  alarm_date[`MONTH_POS +: 5];
   wire m_time = m_sec && m_min && m_hour;

   reg match;
   always @* begin
      case (alarm_interval_select)
         `MASK_SECOND: match = 1'b1;
         `MASK_TEN_SEC: match = m_sec_u;
         `MASK_MINUTE: match = m_sec;
         `MASK_TEN_MIN: match = m_sec && m_min_u;
         `MASK_HOUR: match = m_sec && m_min;
         `MASK_DAY: match = m_time;
         `MASK_WEEK: match = m_time && m_wday;
         `MASK_MONTH: match = m_time && m_day;
         `MASK_YEAR: match = m_time && m_day && m_month;
         default: match = 1'b0;
      endcase
   end

   // Compare the freshly advanced time, one cycle after the update
   wire alarm_event = alarm_enable && module_on &&
      (((alarm_interval_select == `MASK_HALF_SEC) && half_tick) ||
       (sec_new && match));

   // ----------------------------------------------------------------
   // Bus channel handshakes
   // ----------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready <= 1'b0;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_full <= 1'b1;
            awready <= 1'b0;
            aw_addr_q <= awaddr;
         end else if (!aw_full && !bvalid && !awready) begin
            awready <= 1'b1;
         end
         if (wvalid && wready) begin
            w_full <= 1'b1;
            wready <= 1'b0;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end else if (!w_full && !bvalid && !wready) begin
            wready <= 1'b1;
         end
         if (do_write) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            bvalid <= 1'b1;
            bresp <= addr_ok(aw_addr_q) ? `RESP_OKAY : `RESP_DECERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= reg_image(araddr);
            rresp <= addr_ok(araddr) ? `RESP_OKAY : `RESP_DECERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
         end else if (!rvalid && !arready) begin
            arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Timebase, calendar and alarm state
   // ----------------------------------------------------------------
   // A bus write in the same cycle as a hardware update wins for the fields it
   // sets; a time or date write while writes are locked is dropped, and so is the pulse bit while the alarm is on.
   always @(posedge aclk) begin
      if (!aresetn) begin
         module_on <= 1'b0;
         value_write_enable <= 1'b0;
         half_second_status <= 1'b0;
         alarm_read_unsafe_flag <= 1'b0;
         alarm_enable <= 1'b0;
         repeat_wrap <= 1'b0;
         alarm_pulse <= 1'b0;
         alarm_interval_select <= `MASK_RESET;
         alarm_repeat_count <= `REPEAT_RESET;
         time_value <= `TIME_RESET;
         date_value <= `DATE_RESET;
         alarm_time <= `ALARM_TIME_RESET;
         alarm_date <= `ALARM_DATE_RESET;
         pre_cnt <= 26'h0000000;
         sec_new <= 1'b0;
      end else begin
         alarm_read_unsafe_flag <= near_rollover;
         sec_new <= sec_tick;
         if (!module_on || half_tick) begin
            pre_cnt <= 26'h0000000;
         end else begin
            pre_cnt <= pre_cnt + 26'h0000001;
         end
         if (half_tick) begin
            half_second_status <= ~half_second_status;
         end
         if (sec_tick) begin
            time_value <= time_next;
            date_value <= date_next;
         end

         if (alarm_event) begin
            alarm_pulse <= ~alarm_pulse;
            if (alarm_repeat_count == 8'h00) begin
               if (repeat_wrap) begin
                  alarm_repeat_count <= 8'hFF;
               end else begin
                  alarm_enable <= 1'b0;
               end
            end else begin
               alarm_repeat_count <= alarm_repeat_count - 8'h01;
            end
         end

         if (do_write) begin
            case (wr_base)
               `CTRL_OFFSET: begin
                  // The on bit is locked unless writes are enabled
                  if (value_write_enable) begin
                     module_on <= wv[`CTRL_ON_BIT];
                  end
                  value_write_enable <= wv[`CTRL_WREN_BIT];
               end
               `ALARM_CTRL_OFFSET: begin
                  alarm_enable <= wv[`ENABLE_BIT];
                  repeat_wrap <= wv[`WRAP_BIT];
                  alarm_interval_select <= wv[`MASK_POS +: 4];
                  alarm_repeat_count <= wv[`REPEAT_POS +: 8];
                  // Pulse level is preset only while the alarm is off
                  if (!alarm_enable) begin
                     alarm_pulse <= wv[`PULSE_BIT];
                  end
               end
               `TIME_OFFSET: begin
                  if (value_write_enable) begin
                     time_value <= wv & `TIME_MASK;
                     if (w_strb_q[1]) begin
                        half_second_status <= 1'b0;
                     end
                  end
               end
               `DATE_OFFSET: begin
                  if (value_write_enable) begin
                     date_value <= wv & `DATE_MASK;
                  end
               end
               `ALARM_TIME_OFFSET: begin
                  alarm_time <= wv & `TIME_MASK;
               end
               `ALARM_DATE_OFFSET: begin
                  alarm_date <= wv & `ALARM_DATE_MASK;
               end
               default: begin
                  alarm_time <= alarm_time;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// *** hdl/rtc_consts.vh ***
// Constants of the real-time clock value and alarm block.
// Assumes a single 100 MHz bus clock and an AXI4-Lite register port.
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CTRL_OFFSET 8'h00
`define ALARM_CTRL_OFFSET 8'h04
`define TIME_OFFSET 8'h08
`define DATE_OFFSET 8'h0C
`define ALARM_TIME_OFFSET 8'h10
`define ALARM_DATE_OFFSET 8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SEC_POS 8
`define MIN_POS 16
`define HOUR_POS 24
`define WDAY_POS 0
`define DAY_POS 8
`define MONTH_POS 16
`define YEAR_POS 24
`define REPEAT_POS 0
`define MASK_POS 8
`define SYNC_BIT 12
`define PULSE_BIT 13
`define WRAP_BIT 14
`define ENABLE_BIT 15
`define CTRL_ON_BIT 15
`define CTRL_WREN_BIT 3
`define CTRL_SYNC_BIT 2
`define CTRL_HALF_BIT 1

// ----------------------------------------------------------------
// Implemented bits and reset values
// ----------------------------------------------------------------
`define TIME_MASK 32'h3F7F7F00
`define DATE_MASK 32'hFF1F3F07
`define ALARM_DATE_MASK 32'h001F3F07
`define TIME_RESET 32'h00000000
`define DATE_RESET 32'h00010100
`define ALARM_TIME_RESET 32'h00000000
`define ALARM_DATE_RESET 32'h00010100
`define REPEAT_RESET 8'h00
`define MASK_RESET 4'h0

// ----------------------------------------------------------------
// Interval select codes
// ----------------------------------------------------------------
`define MASK_HALF_SEC 4'h0
`define MASK_SECOND 4'h1
`define MASK_TEN_SEC 4'h2
`define MASK_MINUTE 4'h3
`define MASK_TEN_MIN 4'h4
`define MASK_HOUR 4'h5
`define MASK_DAY 4'h6
`define MASK_WEEK 4'h7
`define MASK_MONTH 4'h8
`define MASK_YEAR 4'h9

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HALF_SEC_MS 32'h000001F4
`define CLK_KHZ 32'h000186A0
`define SYNC_GUARD_CYCLES 32'h00000020

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// *** hdl/bcd_calendar.v ***
// Next-second value of the BCD time and date registers.
// Purely combinational; the caller loads the result on a seconds tick.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_consts.vh"
module bcd_calendar (
   input wire [31:0] time_now,
   input wire [31:0] date_now,
   output reg [31:0] time_next,
   output reg [31:0] date_next
);

   function [7:0] bcd_inc;
      input [7:0] v;
      begin
         if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
         end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
         end
      end
   endfunction

   reg [7:0] sec, min, hour, day, month, year;
   reg [2:0] wday;
   reg leap;
   reg [7:0] last_day;
   reg carry_min, carry_hour, carry_day, carry_mon, carry_year;
   reg [7:0] next_sec, next_min, next_hour, next_day, next_month, next_year;

   always @* begin
      sec = {1'b0, time_now[`SEC_POS +: 7]};
      min = {1'b0, time_now[`MIN_POS +: 7]};
      hour = {2'b00, time_now[`HOUR_POS +: 6]};
      day = {2'b00, date_now[`DAY_POS +: 6]};
      month = {3'b000, date_now[`MONTH_POS +: 5]};
      year = date_now[`YEAR_POS +: 8];
      wday = date_now[`WDAY_POS +: 3];
      // Two-digit year: every fourth year counts as leap
      if (year[4]) begin
         leap = (year[3:0] == 4'h2) || (year[3:0] == 4'h6);
      end else begin
         leap = (year[3:0] == 4'h0) || (year[3:0] == 4'h4) ||
                (year[3:0] == 4'h8);
      end
      case (month)
         8'h02: last_day = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
         default: last_day = 8'h31;
      endcase
      carry_min = (sec == 8'h59);
      carry_hour = carry_min && (min == 8'h59);
      carry_day = carry_hour && (hour == 8'h23);
      carry_mon = carry_day && (day == last_day);
      carry_year = carry_mon && (month == 8'h12);
      next_sec = carry_min ? 8'h00 : bcd_inc(sec);
      next_min = carry_hour ? 8'h00 : bcd_inc(min);
      next_hour = carry_day ? 8'h00 : bcd_inc(hour);
      next_day = carry_mon ? 8'h01 : bcd_inc(day);
      next_month = carry_year ? 8'h01 : bcd_inc(month);
      next_year = (year == 8'h99) ? 8'h00 : bcd_inc(year);
      time_next = time_now;
      date_next = date_now;
      time_next[`SEC_POS +: 7] = next_sec[6:0];
      if (carry_min) begin
         time_next[`MIN_POS +: 7] = next_min[6:0];
      end
      if (carry_hour) begin
         time_next[`HOUR_POS +: 6] = next_hour[5:0];
      end
      if (carry_day) begin
         date_next[`DAY_POS +: 6] = next_day[5:0];
         date_next[`WDAY_POS +: 3] = (wday == 3'h6) ? 3'h0 : wday + 3'h1;
      end
      if (carry_mon) begin
         date_next[`MONTH_POS +: 5] = next_month[4:0];
      end
      if (carry_year) begin
         date_next[`YEAR_POS +: 8] = next_year;
      end
   end

endmodule
`default_nettype wire

// *** verification/rtc_alarm_core_asserts.sv ***
// Checker for the bus handshakes and alarm pulse of rtc_alarm_core.
// Sees only the top module's ports; bound from the testbench top file.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_consts.vh"
module rtc_alarm_core_asserts #(
   parameter integer HALF_SEC_CYCLES = 100
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic alarm_pulse
);
   reg [7:0] last_ar;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ------------------------------------------------------------
   // Read address tracker
   // ------------------------------------------------------------
   // Only needed to know which register a read answer belongs to
   always @(posedge aclk) begin
      if (arvalid && arready) begin
         last_ar <= araddr;
      end
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   // Both halves land in holding registers first, so the answer is two
   // edges after the take
   a_write_answer: assert property (awvalid && awready && wvalid && wready
      |-> ##2 bvalid) else $error("write response late");
   a_bresp_stands: assert property (bvalid && !bready
      |=> bvalid && $stable(bresp)) else $error("write response dropped");
   a_write_reopen: assert property (bvalid && bready
      |=> !bvalid ##1 (awready && wready)) else $error("write not reopened");
   a_write_busy: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while answer pending");
   a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read data late");
   a_rdata_stands: assert property (rvalid && !rready
      |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data changed while pending");
   a_read_reopen: assert property (rvalid && rready |=> !rvalid ##1 arready)
      else $error("read not reopened");
   a_unmapped_zero: assert property (rvalid && rresp == `RESP_DECERR |-> rdata == 32'h00000000)
      else $error("unmapped read data not zero");
   a_time_unused: assert property (rvalid && (last_ar == `TIME_OFFSET || last_ar == `ALARM_TIME_OFFSET) |-> (rdata & 32'hC0808080) == 32'h0)
      else $error("unused time bits not zero");
   a_pulse_spacing: assert property ($changed(alarm_pulse) |=> $stable(alarm_pulse) [*8])
      else $error("alarm events too close");
   c_unmapped: cover property (rvalid && rresp == `RESP_DECERR);
   c_alarm: cover property ($changed(alarm_pulse));
   c_write: cover property (bvalid && bready);
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for rtc_alarm_core over its AXI4-Lite port.
// Assumes a short half-second count so that seconds pass quickly.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_consts.vh"
module tb_top;
   localparam integer HALF = 100;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   wire awready, wready, bvalid, arready, rvalid, alarm_pulse;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int mismatches = 0, num_checks = 0, toggles = 0, n;
   logic [31:0] rv;
   logic [1:0] rr, wb;
   always #5 aclk = ~aclk;
   always @(alarm_pulse) toggles = toggles + 1;
   rtc_alarm_core #(.HALF_SEC_CYCLES(HALF)) dut (.aclk(aclk),
      .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .alarm_pulse(alarm_pulse));
   // ------------------------------------------------------------
   // Bus tasks
   // ------------------------------------------------------------
   task check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Address and data are offered together and dropped as each is taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      wb = bresp;
      bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rv = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask
   task rdc(input string what, input logic [7:0] a, input logic [31:0] e);
      rd(a);
      check(what, rv, e);
   endtask
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rdc("time reset", `TIME_OFFSET, 32'h00000000);
      rdc("date reset", `DATE_OFFSET, 32'h00010100);
      rdc("alarm ctrl reset", `ALARM_CTRL_OFFSET, 32'h00000000);
      rdc("alarm date reset", `ALARM_DATE_OFFSET, 32'h00010100);
      rdc("unmapped read", 8'h40, 32'h00000000);
      check("unmapped rresp", {30'h0, rr}, 32'h00000003);
      wr(8'h40, 32'hFFFFFFFF);
      check("unmapped bresp", {30'h0, wb}, 32'h00000003);
      wr(`TIME_OFFSET, 32'h12345600);
      rdc("locked time", `TIME_OFFSET, 32'h00000000);
      wr(`DATE_OFFSET, 32'h12121200);
      rdc("locked date", `DATE_OFFSET, 32'h00010100);
      wr(`CTRL_OFFSET, 32'h00000008);
      check("okay bresp", {30'h0, wb}, 32'h00000000);
      wr(`TIME_OFFSET, 32'hFFFFFFFF);
      rdc("time bits", `TIME_OFFSET, 32'h3F7F7F00);
      wr(`DATE_OFFSET, 32'hFFFFFFFF);
      rdc("date bits", `DATE_OFFSET, 32'hFF1F3F07);
      wr(`ALARM_TIME_OFFSET, 32'hFFFFFFFF);
      rdc("alarm time bits", `ALARM_TIME_OFFSET, 32'h3F7F7F00);
      wr(`ALARM_DATE_OFFSET, 32'hFFFFFFFF);
      rdc("alarm date bits", `ALARM_DATE_OFFSET, 32'h001F3F07);
      for (int i = 0; i < 16; i++) begin
         wr(`ALARM_CTRL_OFFSET, {20'h0, i[3:0], 8'h00});
         rdc("interval", `ALARM_CTRL_OFFSET, {20'h0, i[3:0], 8'h00});
      end
      // Last second of a non-leap year, Saturday, then switch on
      wr(`TIME_OFFSET, 32'h23595900);
      wr(`DATE_OFFSET, 32'h99123106);
      wr(`CTRL_OFFSET, 32'h00008008);
      repeat (2 * HALF + 50) @(posedge aclk);
      rdc("midnight", `TIME_OFFSET, 32'h00000000);
      rdc("new year", `DATE_OFFSET, 32'h00010100);
      n = 0;
      do begin
         rd(`CTRL_OFFSET);
         n++;
      end while (rv[1] !== 1'b1 && n < 60);
      check("half status set", {31'h0, rv[1]}, 32'h00000001);
      // Status was just seen rising, so the prescaler is near its wrap
      check("unsafe flag", {31'h0, rv[2]}, 32'h00000001);
      wr(`TIME_OFFSET, 32'h00000100);
      rd(`CTRL_OFFSET);
      check("half status cleared", {31'h0, rv[1]}, 32'h00000000);
      // Alarm control is only rewritten while the module is off
      wr(`CTRL_OFFSET, 32'h00000008);
      wr(`ALARM_CTRL_OFFSET, 32'h00008002);
      toggles = 0;
      wr(`CTRL_OFFSET, 32'h00008008);
      repeat (5 * HALF) @(posedge aclk);
      check("alarm events", toggles, 32'h00000003);
      rd(`ALARM_CTRL_OFFSET);
      check("repeat exhausted", rv & 32'h0000C0FF, 32'h00000000);
      wr(`CTRL_OFFSET, 32'h00000008);
      wr(`ALARM_CTRL_OFFSET, 32'h0000C100);
      toggles = 0;
      wr(`CTRL_OFFSET, 32'h00008008);
      n = 0;
      while (toggles == 0 && n < 3 * HALF) begin
         @(posedge aclk);
         n++;
      end
      wr(`CTRL_OFFSET, 32'h00000008);
      rd(`ALARM_CTRL_OFFSET);
      check("repeat wrap", rv & 32'h0000C0FF, 32'h0000C0FF);
      end_sim;
   end
   // Run needs about 1150 cycles; a hang is cut well beyond that
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      end_sim;
   end
endmodule
bind rtc_alarm_core rtc_alarm_core_asserts #(
   .HALF_SEC_CYCLES(HALF_SEC_CYCLES)) chk (.aclk(aclk), .aresetn(aresetn),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
   .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
   .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
   .rvalid(rvalid), .rready(rready), .alarm_pulse(alarm_pulse));
`default_nettype wire
